// file: tb/testbench.sv
// Purpose: self-checking bench of the flash program/erase sequencer
// Assumes: 50 MHz clock, protect byte and low-power request driven here
// Notes: a byte model in an associative array predicts every array read
`timescale 1ns/100ps
`default_nettype none
`include "fpe_params.svh"
module testbench;
    import fpe_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [7:0] prot = 8'hff;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, lp = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] rdata, rv;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, pump, hv;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'h2d7f;
    logic [7:0] mem [int];
    logic [7:0] d;
    fpe_top u_fpe_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .protect_start_bits(prot), .low_power_req(lp), .charge_pump_on(pump), .array_hv_on(hv));
    // free-running bus clock
    initial begin
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // control write, then readback of the control bits and both pump outputs
    task automatic ctl(input logic [3:0] v, input logic [3:0] e);
        wr(`FPE_OFF_CTRL, {28'h0, v});
        chk("bresp", {30'h0, rs}, {30'h0, `FPE_RESP_OK});
        rd(`FPE_OFF_CTRL);
        chk("ctrl", rv, {28'h0, e});
        chk("pump", {30'h0, pump, hv}, {30'h0, e[3], e[3]});
    endtask
    // select, protect read, latch write, then ask for high voltage
    task automatic arm(input logic [3:0] sel, input logic [15:0] a, input logic [3:0] e);
        ctl(sel, sel);
        rd(`FPE_OFF_PROT);
        chk("prot", rv, {24'h0, prot});
        wr(`FPE_OFF_ADDR, {16'h0, a});
        wr(`FPE_OFF_DATA, 32'h0);
        ctl(sel | 4'h8, e);
    endtask
    task automatic rdarr(input logic [15:0] a);
        wr(`FPE_OFF_ADDR, {16'h0, a});
        rd(`FPE_OFF_DATA);
        chk("array", rv, {24'h0, mem[a]});
    endtask
    // sticky refusal flag must be set; clear it for the next case
    task automatic refused();
        rd(`FPE_OFF_STAT);
        chk("refused", {31'h0, rv[`FPE_S_REF]}, 32'h1);
        wr(`FPE_OFF_STAT, 32'h10);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog sized well beyond one mass erase plus the short cases
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        ctl(4'h0, 4'h0);
        // whole-array erase also clears the trim byte
        arm(4'h6, 16'hf000, 4'he);
        ctl(4'h8, 4'h8);
        for (int i = 16'hee00; i <= 16'hfdff; i++) mem[i] = 8'hff;
        for (int i = 16'hffc0; i <= 16'hffff; i++) mem[i] = 8'hff;
        rdarr(16'hffc0);
        ctl(4'h0, 4'h0);
        rdarr(16'hee00);
        // two rows: ends of each row programmed, next row refused
        for (int k = 0; k < 2; k++) begin
            logic [15:0] r;
            r = (k == 0) ? 16'hfdc0 : 16'hffc0;
            arm(4'h1, r, 4'h9);
            // bytes go out back to back, well inside the maximum program time
            for (int j = 0; j < 3; j++) begin
                d = $random(seed);
                // highest address used is fffe, so the watchdog clear byte is never hit
                wr(`FPE_OFF_ADDR, {16'h0, r + 16'(j * 31)});
                wr(`FPE_OFF_DATA, {24'h0, d});
                // rows were just erased, so every programmed byte starts at ff
                if (j < 2) mem[r + j * 31] = mem[r + j * 31] & d;
            end
            refused();
            ctl(4'h8, 4'h8);
            ctl(4'h0, 4'h0);
            for (int j = 0; j < 3; j++) rdarr(r + 16'(j * 31));
        end
        // vector page erase chosen by the latched address
        arm(4'h2, 16'hffe5, 4'ha);
        ctl(4'h8, 4'h8);
        for (int i = 16'hffc0; i <= 16'hffff; i++) mem[i] = 8'hff;
        rdarr(16'hffc0);
        ctl(4'h0, 4'h0);
        rdarr(16'hfdc0);
        // both selects at once, and high voltage without the protect read
        ctl(4'h3, 4'h0);
        refused();
        ctl(4'h1, 4'h1);
        ctl(4'h9, 4'h1);
        refused();
        ctl(4'h0, 4'h0);
        // protect byte fe opens all but the top 128 bytes
        prot <= 8'hfe;
        rd(`FPE_OFF_STAT);
        chk("start", {16'h0, rv[31:16]}, {16'h0, 2'b11, 8'hfe, 6'h0});
        arm(4'h2, 16'hffc0, 4'h2);
        refused();
        ctl(4'h0, 4'h0);
        arm(4'h6, 16'hee00, 4'h6);
        refused();
        ctl(4'h0, 4'h0);
        arm(4'h1, 16'hee00, 4'h9);
        // low-power entry drops all selects and high voltage
        lp <= 1'b1;
        @(posedge aclk);
        lp <= 1'b0;
        rd(`FPE_OFF_CTRL);
        chk("abort", rv, 32'h0);
        chk("abort_pump", {31'h0, pump}, 32'h0);
        rd(8'h20);
        chk("unmapped", {30'h0, rs}, {30'h0, `FPE_RESP_ERR});
        close_out();
    end
endmodule // testbench
`default_nettype wire

// file: verilog/fpe_arr_if.sv
// Purpose: link between sequencer and array store
// Assumes: one clock
// Notes: reads are combinational
`timescale 1ns/100ps
`default_nettype none
interface fpe_arr_if #(parameter int IDXW = 13);
    logic [IDXW-1:0] rd_idx;
    logic [7:0] rd_data;
    logic wr_en;
    logic [IDXW-1:0] wr_idx;
    logic [7:0] wr_data;
    logic er_start;
    logic [IDXW-1:0] er_base;
    logic [IDXW-1:0] er_last;
    logic er_busy;
    modport ctl (output rd_idx, wr_en, wr_idx, wr_data, er_start, er_base, er_last,
                 input rd_data, er_busy);
    modport mem (input rd_idx, wr_en, wr_idx, wr_data, er_start, er_base, er_last,
                 output rd_data, er_busy);
endinterface
`default_nettype wire

// file: verilog/fpe_array.sv
// Purpose: byte store of the flash array with a walking eraser
// Assumes: contents are not reset
// Notes: erase clears one byte per clock
`timescale 1ns/100ps
`default_nettype none
`include "fpe_params.svh"
module fpe_array #(
    parameter int DEPTH = 4160,
    parameter int IDXW = 13
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sequencer side
    fpe_arr_if.mem arr
);
    logic [7:0] mem [0:DEPTH-1];
    logic busy_r, busy_nxt;
    logic [IDXW-1:0] ptr_r, ptr_nxt, last_r, last_nxt;

    // erase walker
    always_comb begin
        busy_nxt = busy_r;
        ptr_nxt = ptr_r;
        last_nxt = last_r;
        if (arr.er_start) begin
            busy_nxt = 1'b1;
            ptr_nxt = arr.er_base;
            last_nxt = arr.er_last;
        end else if (busy_r) begin
            if (ptr_r == last_r) busy_nxt = 1'b0;
            else ptr_nxt = ptr_r + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
            ptr_r <= '0;
            last_r <= '0;
        end else begin
            busy_r <= busy_nxt;
            ptr_r <= ptr_nxt;
            last_r <= last_nxt;
        end
    end

    // erased bits read one, programming can only pull bits to zero
    always_ff @(posedge aclk) begin
        if (busy_r) mem[ptr_r] <= `FPE_ERASED;
        else if (arr.wr_en) mem[arr.wr_idx] <= mem[arr.wr_idx] & arr.wr_data;
    end

    assign arr.rd_data = mem[arr.rd_idx];
    assign arr.er_busy = busy_r;
endmodule // fpe_array
`default_nettype wire

// file: verilog/fpe_params.svh
// Purpose: offsets, field positions, array geometry and timing counts
// Assumes: one 50 MHz bus clock
// Notes: definitions only
`ifndef FPE_PARAMS_SVH
`define FPE_PARAMS_SVH
// register byte offsets
`define FPE_OFF_CTRL 8'h00
`define FPE_OFF_STAT 8'h04
`define FPE_OFF_ADDR 8'h08
`define FPE_OFF_DATA 8'h0c
`define FPE_OFF_PROT 8'h10
// flash_operation_control fields
`define FPE_B_PGM 0
`define FPE_B_ERS 1
`define FPE_B_MASS 2
`define FPE_B_HV 3
// status fields
`define FPE_S_PREAD 0
`define FPE_S_LAT 1
`define FPE_S_RCV 2
`define FPE_S_BUSY 3
`define FPE_S_REF 4
`define FPE_S_START 16
// array geometry
`define FPE_USER_BYTES 4096
`define FPE_PAGE_BYTES 64
`define FPE_PAGE_LSB 6
`define FPE_ROW_LSB 5
`define FPE_USER_TOP 16'hfdff
`define FPE_VEC_BASE 16'hffc0
`define FPE_PROT_OPEN 8'hff
`define FPE_ERASED 8'hff
// timing
`define FPE_CLK_NS 20
`define FPE_RCV_NS 1000
`define FPE_RCV_CYC ((`FPE_RCV_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
// bus answers
`define FPE_RESP_OK 2'b00
`define FPE_RESP_ERR 2'b10
`endif

// file: verilog/fpe_pkg.sv
// Purpose: types of the flash sequencer
// Assumes: nothing
// Notes: gray codes along idle-sel-pread-armed-hv-recov
`default_nettype none
package fpe_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SEL = 3'h1,
        ST_PREAD = 3'h3,
        ST_ARMED = 3'h2,
        ST_HV = 3'h6,
        ST_RECOV = 3'h7
    } fpe_state_t;
endpackage
`default_nettype wire

// file: verilog/fpe_prot.sv
// Purpose: protected range decode
// Assumes: protect byte is stable during an operation
// Notes: all ones opens the whole array
`timescale 1ns/100ps
`default_nettype none
`include "fpe_params.svh"
module fpe_prot (
    // protect byte and address under test
    input wire logic [7:0] prot_bits,
    input wire logic [15:0] addr,
    // decode
    output logic [15:0] start_addr,
    output logic hit,
    output logic open_all
);
    // start address is 64-byte aligned inside the top 16 kbyte
    assign start_addr = {2'b11, prot_bits, 6'h00};
    assign open_all = (prot_bits == `FPE_PROT_OPEN);
    assign hit = !open_all && (addr >= start_addr);
endmodule // fpe_prot
`default_nettype wire

// file: verilog/fpe_top.sv
// Purpose: program/erase sequencer of an embedded flash
// Assumes: AXI4-Lite, one write and one read in flight
// Notes: array reached through ADDR and DATA registers
// What this block does
// - user array 4096 or 1536 plus vectors
// - erased reads one, programmed reads zero
// - high voltage only after proper sequence
// - high voltage drives pump and array
// - program and erase never both set
// - 64-byte pages, vector area one page
// - array write latches erase page address
// - mass erase blocked unless protect all ones
// - vector or mass erase clears trim
// - one program cycle stays in row
// - program select latches write address, data
// - protected address refuses high voltage
// - protected range runs to top
// - protect read needed before high voltage
// - about 1 us recovery after high voltage
// - protect bits form address bits 13..6
// - low-power entry drops selects and high voltage; an erase walk already started still runs to its end
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fpe_params.svh"
module fpe_top
    import fpe_pkg::*;
#(
    parameter int USER_BYTES = `FPE_USER_BYTES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // device side
    input wire logic [7:0] protect_start_bits,
    input wire logic low_power_req,
    output logic charge_pump_on,
    output logic array_hv_on
);
    localparam int DEPTH = USER_BYTES + `FPE_PAGE_BYTES;
    localparam int IDXW = $clog2(DEPTH);
    localparam int RCV_CYC = `FPE_RCV_CYC;
    localparam int CW = $clog2(RCV_CYC + 1);
    localparam logic [15:0] USER_BASE = 16'(`FPE_USER_TOP + 1 - USER_BYTES);

    fpe_arr_if #(.IDXW(IDXW)) arr ();

    // bus state
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt, ar_addr_r, ar_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, ar_full_r, ar_full_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    // control state
    fpe_state_t st_r, st_nxt;
    logic pgm_r, pgm_nxt, ers_r, ers_nxt, mass_r, mass_nxt, hv_r, hv_nxt;
    logic ref_r, ref_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [15:0] addr_r, addr_nxt, lat_r, lat_nxt;
    // decode
    logic wr_go, rd_go, rd_stall, wr_ok, rd_ok;
    logic ctrl_wr, data_wr, sel_chg, hv_try, hv_acc, row_ok, pgm_ok;
    logic v_pgm, v_ers, v_mass, v_hv;
    logic prot_hit, prot_open;
    logic [15:0] prot_start;
    logic [IDXW:0] cur_map, lat_map;
    logic [31:0] rd_val;

    // address to array index; top bit flags a mapped address
    function automatic logic [IDXW:0] map_addr(input logic [15:0] a);
        logic [15:0] off;
        off = a - USER_BASE;
        if (a >= `FPE_VEC_BASE) begin
            map_addr = {1'b1, IDXW'(USER_BYTES + int'(a[`FPE_PAGE_LSB-1:0]))};
        end else if (a >= USER_BASE && a <= `FPE_USER_TOP) begin
            map_addr = {1'b1, off[IDXW-1:0]};
        end else begin
            map_addr = '0;
        end
    endfunction

    fpe_array #(.DEPTH(DEPTH), .IDXW(IDXW)) u_array (
        .aclk(aclk),
        .aresetn(aresetn),
        .arr(arr.mem)
    );

    // protection is judged on the latched address; a row never straddles
    // a 64-byte protect boundary, so this also covers every byte written
    fpe_prot u_prot (
        .prot_bits(protect_start_bits),
        .addr(lat_r),
        .start_addr(prot_start),
        .hit(prot_hit),
        .open_all(prot_open)
    );

    // handshakes
    assign awready = !aw_full_r;
    assign wready = !w_full_r;
    assign arready = !ar_full_r && !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign charge_pump_on = hv_r;
    assign array_hv_on = hv_r;

    // request decode
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;
    assign wr_ok = (aw_addr_r == `FPE_OFF_CTRL) || (aw_addr_r == `FPE_OFF_STAT) ||
                   (aw_addr_r == `FPE_OFF_ADDR) || (aw_addr_r == `FPE_OFF_DATA);
    // array reads wait out recovery and any running erase
    assign rd_stall = (ar_addr_r == `FPE_OFF_DATA) && (st_r == ST_RECOV || arr.er_busy);
    assign rd_go = ar_full_r && !rvalid_r && !wr_go && !rd_stall;
    assign v_pgm = w_data_r[`FPE_B_PGM];
    assign v_ers = w_data_r[`FPE_B_ERS];
    assign v_mass = w_data_r[`FPE_B_MASS];
    assign v_hv = w_data_r[`FPE_B_HV];
    assign ctrl_wr = wr_go && aw_addr_r == `FPE_OFF_CTRL && w_strb_r[0];
    assign data_wr = wr_go && aw_addr_r == `FPE_OFF_DATA && w_strb_r[0];
    assign sel_chg = {v_mass, v_ers, v_pgm} != {mass_r, ers_r, pgm_r};
    assign cur_map = map_addr(addr_r);
    assign lat_map = map_addr(lat_r);
    assign row_ok = addr_r[15:`FPE_ROW_LSB] == lat_r[15:`FPE_ROW_LSB];

    // high voltage request and its interlocks
    assign hv_try = ctrl_wr && v_hv && !hv_r && !(v_pgm && v_ers);
    assign hv_acc = hv_try && st_r == ST_ARMED && !sel_chg && lat_map[IDXW] &&
                    !prot_hit &&
                    (!mass_r || prot_open) &&
                    !low_power_req;

    // byte program under high voltage, only inside the latched row
    assign pgm_ok = data_wr && st_r == ST_HV && pgm_r && row_ok && !prot_hit &&
                    !arr.er_busy && !low_power_req;
    assign arr.wr_en = pgm_ok;
    assign arr.wr_idx = cur_map[IDXW-1:0];
    assign arr.wr_data = w_data_r[7:0];
    assign arr.rd_idx = cur_map[IDXW-1:0];

    // erase runs when erase select drops with high voltage on
    assign arr.er_start = ctrl_wr && st_r == ST_HV && ers_r && !v_ers && !v_pgm && !low_power_req;
    // a vector page or whole-array erase also wipes the trim byte
    assign arr.er_base = mass_r ? '0 : {lat_map[IDXW-1:`FPE_PAGE_LSB], {`FPE_PAGE_LSB{1'b0}}};
    assign arr.er_last = mass_r ? IDXW'(DEPTH - 1) :
                         {lat_map[IDXW-1:`FPE_PAGE_LSB], {`FPE_PAGE_LSB{1'b1}}};

    // read mux
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case (ar_addr_r)
            `FPE_OFF_CTRL: begin
                rd_val[`FPE_B_PGM] = pgm_r;
                rd_val[`FPE_B_ERS] = ers_r;
                rd_val[`FPE_B_MASS] = mass_r;
                rd_val[`FPE_B_HV] = hv_r;
            end
            `FPE_OFF_STAT: begin
                rd_val[`FPE_S_PREAD] = st_r == ST_PREAD || st_r == ST_ARMED || st_r == ST_HV;
                rd_val[`FPE_S_LAT] = st_r == ST_ARMED || st_r == ST_HV;
                rd_val[`FPE_S_RCV] = st_r == ST_RECOV;
                rd_val[`FPE_S_BUSY] = arr.er_busy;
                rd_val[`FPE_S_REF] = ref_r;
                rd_val[31:`FPE_S_START] = prot_start;
            end
            `FPE_OFF_ADDR: rd_val[15:0] = addr_r;
            `FPE_OFF_DATA: rd_val[7:0] = cur_map[IDXW] ? arr.rd_data : `FPE_ERASED;
            `FPE_OFF_PROT: rd_val[7:0] = protect_start_bits;
            default: rd_ok = 1'b0;
        endcase
    end

    // bus channels: hold each request until both halves of a write are in
    always_comb begin
        aw_full_nxt = aw_full_r;
        aw_addr_nxt = aw_addr_r;
        w_full_nxt = w_full_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ar_full_nxt = ar_full_r;
        ar_addr_nxt = ar_addr_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (awvalid && awready) begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = awaddr;
        end
        if (wvalid && wready) begin
            w_full_nxt = 1'b1;
            w_data_nxt = wdata;
            w_strb_nxt = wstrb;
        end
        if (wr_go) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? `FPE_RESP_OK : `FPE_RESP_ERR;
        end
        if (bvalid_r && bready) bvalid_nxt = 1'b0;
        if (arvalid && arready) begin
            ar_full_nxt = 1'b1;
            ar_addr_nxt = araddr;
        end
        if (rd_go) begin
            ar_full_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_val;
            rresp_nxt = rd_ok ? `FPE_RESP_OK : `FPE_RESP_ERR;
        end
        if (rvalid_r && rready) rvalid_nxt = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `FPE_RESP_OK;
            ar_full_r <= 1'b0;
            ar_addr_r <= 8'h00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `FPE_RESP_OK;
        end else begin
            aw_full_r <= aw_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_full_r <= w_full_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            ar_full_r <= ar_full_nxt;
            ar_addr_r <= ar_addr_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // operation sequencer
    always_comb begin
        st_nxt = st_r;
        pgm_nxt = pgm_r;
        ers_nxt = ers_r;
        mass_nxt = mass_r;
        hv_nxt = hv_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        lat_nxt = lat_r;
        ref_nxt = ref_r;
        if (st_r == ST_RECOV) begin
            if (cnt_r == '0) st_nxt = ST_IDLE;
            else cnt_nxt = cnt_r - 1'b1;
        end
        // clear first so that a refusal in the same write still sets it
        if (wr_go && aw_addr_r == `FPE_OFF_STAT && w_strb_r[0] && w_data_r[`FPE_S_REF]) ref_nxt = 1'b0;
        if (wr_go && aw_addr_r == `FPE_OFF_ADDR) begin
            if (w_strb_r[0]) addr_nxt[7:0] = w_data_r[7:0];
            if (w_strb_r[1]) addr_nxt[15:8] = w_data_r[15:8];
        end
        if (ctrl_wr) begin
            if ((v_pgm && v_ers) || st_r == ST_RECOV) begin
                ref_nxt = 1'b1;
            end else if (st_r == ST_HV) begin
                // under high voltage selects may only drop
                pgm_nxt = pgm_r & v_pgm;
                ers_nxt = ers_r & v_ers;
                mass_nxt = mass_r & v_mass;
                if (!v_hv) begin
                    hv_nxt = 1'b0;
                    pgm_nxt = 1'b0;
                    ers_nxt = 1'b0;
                    mass_nxt = 1'b0;
                    st_nxt = ST_RECOV;
                    cnt_nxt = CW'(RCV_CYC - 1);
                end
            end else begin
                pgm_nxt = v_pgm;
                ers_nxt = v_ers;
                mass_nxt = v_mass;
                if (sel_chg) st_nxt = (v_pgm || v_ers) ? ST_SEL : ST_IDLE;
                if (hv_acc) begin
                    hv_nxt = 1'b1;
                    st_nxt = ST_HV;
                end else if (hv_try) begin
                    ref_nxt = 1'b1;
                end
            end
        end
        if (data_wr) begin
            if (st_r == ST_PREAD || st_r == ST_ARMED) begin
                lat_nxt = addr_r;
                st_nxt = ST_ARMED;
            end else if (st_r == ST_HV && pgm_r && !pgm_ok) begin
                ref_nxt = 1'b1;
            end
        end
        // the protect read must sit between select and high voltage
        if (rd_go && ar_addr_r == `FPE_OFF_PROT && st_r == ST_SEL) st_nxt = ST_PREAD;
        // low-power entry drops the operation to standby
        if (low_power_req) begin
            pgm_nxt = 1'b0;
            ers_nxt = 1'b0;
            mass_nxt = 1'b0;
            hv_nxt = 1'b0;
            st_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_IDLE;
            pgm_r <= 1'b0;
            ers_r <= 1'b0;
            mass_r <= 1'b0;
            hv_r <= 1'b0;
            cnt_r <= '0;
            addr_r <= 16'h0000;
            lat_r <= 16'h0000;
            ref_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pgm_r <= pgm_nxt;
            ers_r <= ers_nxt;
            mass_r <= mass_nxt;
            hv_r <= hv_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            lat_r <= lat_nxt;
            ref_r <= ref_nxt;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_SEL_EXCL: assert property (!(pgm_r && ers_r))
        else $error("program and erase select both set");
    AST_HV_SEQ: assert property ($rose(hv_r) |-> $past(st_r) == ST_ARMED)
        else $error("high voltage set out of sequence");
    AST_PREAD: assert property (st_r == ST_SEL |=> st_r != ST_ARMED && st_r != ST_HV)
        else $error("armed without protect read");
    AST_PUMP: assert property (charge_pump_on == (st_r == ST_HV))
        else $error("pump state disagrees with sequencer");
    AST_PROT: assert property ($rose(hv_r) |-> !$past(prot_hit))
        else $error("high voltage on protected address");
    AST_MASS: assert property ($rose(hv_r) && mass_r |-> $past(prot_open))
        else $error("mass erase while protected");
    AST_ROW: assert property (arr.wr_en |-> row_ok && pgm_r && hv_r)
        else $error("program outside latched row");
    AST_LATCH: assert property (data_wr && st_r == ST_PREAD && !low_power_req |=>
        st_r == ST_ARMED && lat_r == $past(addr_r))
        else $error("array write address not latched");
    AST_RCV: assert property ($fell(hv_r) && !$past(low_power_req) |->
        st_r == ST_RECOV ##RCV_CYC st_r == ST_IDLE)
        else $error("recovery time wrong");
    AST_ABORT: assert property (low_power_req |=> !hv_r && !pgm_r && !ers_r && !mass_r)
        else $error("low power did not abort");
    AST_REFUSE: assert property (hv_try && !hv_acc |=> !hv_r && ref_r)
        else $error("refused high voltage took effect");
endmodule // fpe_top
`default_nettype wire
